// >>> hdl/asce_axis.sv
// Per-axis command check, error latch and interrupt feeding state
`timescale 1ns/1ps
module asce_axis (
	input wire logic clk,
	input wire logic sys_rst,
	input asce_pkg::asce_cmd_t cmd,
	input wire logic cmd_valid,
	input wire logic irq_rise,
	input wire logic [31:0] fb_pos,
	input wire logic move_done,
	output asce_pkg::asce_axst_t st,
	output logic stop_req,
	output logic err_pulse,
	output logic ovf_pulse
);
	import asce_pkg::*;
	asce_axst_t next_st;
	logic dir_neg;
	logic next_dir_neg;
	logic spd_zero;
	logic next_spd_zero;
	logic [ERR_W-1:0] err_set;
	logic err_clr;
	logic blocked;
	logic [33:0] travel;
	logic [33:0] sum;
	logic sum_ovf;
	// Travel distance kept from the last feeding command not refused by a latched error or the latch function, range errors or not
	logic [31:0] cmd_pos_q;
	logic [31:0] next_cmd_pos;

	// Travel follows the speed sign; 34 bits keep the sum exact
	assign travel = dir_neg ? (34'h0 - {{2{cmd_pos_q[31]}}, cmd_pos_q})
		: {{2{cmd_pos_q[31]}}, cmd_pos_q};
	assign sum = {{2{fb_pos[31]}}, fb_pos} + travel;
	assign sum_ovf = ~((&sum[33:31]) | ~(|sum[33:31]));
	// New starts are ignored until the host has reset the latched error
	assign blocked = |st.err;

	always_comb
	begin
		next_st = st;
		next_dir_neg = dir_neg;
		next_spd_zero = spd_zero;
		next_cmd_pos = cmd_pos_q;
		err_set = '0;
		err_clr = 1'b0;
		if (irq_rise && st.mode == MODE_WAIT)
		begin
			if (spd_zero)
				err_set[ERR_SPEED] = 1'b1;
			else if (sum_ovf)
			begin
				err_set[ERR_OVF] = 1'b1;
				next_st.ovf_state = 1'b1;
			end
			else
			begin
				next_st.target = sum[31:0];
				next_st.mode = MODE_FEED;
			end
		end
		if (move_done && st.mode == MODE_FEED)
			next_st.mode = MODE_IDLE;
		if (cmd_valid)
		begin
			unique case (cmd.op)
				OP_SPEED:
					if (!blocked)
					begin
						err_set[ERR_SPEED] = cmd.speed_bad;
						err_set[ERR_ACC] = cmd.acc_bad;
						err_set[ERR_DEC] = cmd.dec_bad;
						next_spd_zero = cmd.speed_zero;
						next_dir_neg = cmd.speed_neg;
						if (!(cmd.speed_bad | cmd.acc_bad | cmd.dec_bad))
							next_st.mode = MODE_SPEED;
					end
				OP_IFEED:
					if (!blocked)
					begin
						if (cmd.ifunc_latch)
							err_set[ERR_IFUNC] = 1'b1;
						else
						begin
							err_set[ERR_SPEED] = cmd.speed_bad;
							err_set[ERR_ACC] = cmd.acc_bad;
							err_set[ERR_DEC] = cmd.dec_bad;
							err_set[ERR_POS] = cmd.pos_bad;
							next_spd_zero = cmd.speed_zero;
							next_dir_neg = cmd.speed_neg;
							next_cmd_pos = cmd.pos;
							if (!(cmd.speed_bad | cmd.acc_bad | cmd.dec_bad | cmd.pos_bad))
								next_st.mode = MODE_WAIT;
						end
					end
				OP_CHSPD:
					if (st.mode != MODE_IDLE)
					begin
						// Range, zero while feeding, reversal while waiting
						err_set[ERR_SPEED] = cmd.speed_bad
							| (st.mode == MODE_FEED && cmd.speed_zero)
							| (st.mode == MODE_WAIT && !cmd.speed_zero && !spd_zero
							&& cmd.speed_neg != dir_neg);
						next_spd_zero = cmd.speed_zero;
						if (st.mode != MODE_FEED)
							next_dir_neg = cmd.speed_neg;
					end
				OP_PRESET:
					if (cmd.pos_bad)
						err_set[ERR_PRESET] = 1'b1;
					else
						next_st.ovf_state = err_set[ERR_OVF];
				OP_ERST:
					err_clr = 1'b1;
				OP_STOP:
					next_st.mode = MODE_IDLE;
				default:
					;
			endcase
		end
		// A new error wins over a reset in the same cycle
		next_st.err = (err_clr ? '0 : st.err) | err_set;
		if (|(err_set & STOP_MASK))
			next_st.mode = MODE_IDLE;
	end

	// Overflow state is only left by a good preset, never by error reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st <= '0;
			dir_neg <= 1'b0;
			spd_zero <= 1'b1;
			cmd_pos_q <= RST_WORD;
		end
		else
		begin
			st <= next_st;
			dir_neg <= next_dir_neg;
			spd_zero <= next_spd_zero;
			cmd_pos_q <= next_cmd_pos;
		end
	end

	// Stop request stays up while a stopping error is latched
	assign stop_req = |(st.err & STOP_MASK);
	assign err_pulse = |(err_set & ~st.err);
	assign ovf_pulse = err_set[ERR_OVF];
endmodule

// >>> hdl/asce_err_display.sv
// Error indicator and segment display driver for the lowest failing axis
`timescale 1ns/1ps
module asce_err_display #(
	parameter int NUM_AXES = 16,
	parameter int AXW = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [NUM_AXES-1:0] err_any,
	output logic unit_error_indicator,
	output logic [7:0] segment_display_code,
	output logic [AXW-1:0] segment_display_axis
);
	import asce_pkg::*;
	logic [AXW-1:0] next_axis;

	// Lowest numbered axis wins; axes count from one
	always_comb
	begin
		next_axis = '0;
		for (int i = NUM_AXES - 1; i >= 0; i--)
			if (err_any[i])
				next_axis = AXW'(i + 1);
	end

	// Display shows blank code while no error stands
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			unit_error_indicator <= 1'b0;
			segment_display_code <= 8'h00;
			segment_display_axis <= '0;
		end
		else
		begin
			unit_error_indicator <= |err_any;
			segment_display_code <= (|err_any) ? DISP_AXIS_ERR : 8'h00;
			segment_display_axis <= next_axis;
		end
	end
endmodule

// >>> hdl/asce_pkg.sv
// Shared constants, enumerations and carriers of the axis error checker
package asce_pkg;
	// Register byte offsets on the APB bus
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SPEED = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ACCEL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_DECEL = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_POS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_IFUNC = 8'h14;
	localparam logic [ADDR_W-1:0] REG_AXSEL = 8'h18;
	localparam logic [ADDR_W-1:0] REG_AXSTAT = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_ERRSUM = 8'h20;
	localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h24;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h28;
	localparam logic [ADDR_W-1:0] REG_DISP = 8'h2c;
	localparam logic [ADDR_W-1:0] REG_STOPSUM = 8'h30;
	// Command word fields
	localparam int CMD_OP_LSB = 8;
	localparam int CMD_OP_W = 3;
	// Values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// Error flag positions inside one axis
	localparam int ERR_SPEED = 0;
	localparam int ERR_ACC = 1;
	localparam int ERR_DEC = 2;
	localparam int ERR_POS = 3;
	localparam int ERR_IFUNC = 4;
	localparam int ERR_OVF = 5;
	localparam int ERR_PRESET = 6;
	localparam int ERR_W = 7;
	// Errors that bring the axis to a decelerated stop
	localparam logic [ERR_W-1:0] STOP_MASK = 7'h2f;
	// Sticky interrupt status bits
	localparam int INT_ERR = 0;
	localparam int INT_OVF = 1;
	localparam int INT_DONE = 2;
	localparam int INT_W = 3;
	// Code shown on the segment display while an axis error stands
	localparam logic [7:0] DISP_AXIS_ERR = 8'hae;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_SPEED = 3'b001,
		OP_IFEED = 3'b010,
		OP_CHSPD = 3'b011,
		OP_PRESET = 3'b100,
		OP_ERST = 3'b101,
		OP_STOP = 3'b110
	} asce_op_t;
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_SPEED = 2'b01,
		MODE_WAIT = 2'b10,
		MODE_FEED = 2'b11
	} asce_mode_t;
	typedef struct packed {
		asce_op_t op;
		logic speed_bad;
		logic speed_zero;
		logic speed_neg;
		logic acc_bad;
		logic dec_bad;
		logic pos_bad;
		logic ifunc_latch;
		logic [31:0] pos;
	} asce_cmd_t;
	typedef struct packed {
		asce_mode_t mode;
		logic [ERR_W-1:0] err;
		logic ovf_state;
		logic [31:0] target;
	} asce_axst_t;
endpackage

// >>> hdl/asce_top.sv
// Axis speed control error checker with APB registers and interrupt
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Speed out of range raises speed error
// - Zero speed at interrupt input: speed error
// - Speed changed to zero while feeding: error
// - Speed sign reversed while waiting: error
// - Acceleration time out of range: error
// - Deceleration time out of range: error
// - Feeding travel position out of range: error
// - Latch input function refuses feeding, errors
// - Capture overflow raises present position overflow
// - Overflow state survives error reset, cleared by good preset
// - Preset position out of range: preset error
// - Stopping errors decelerate the axis to stop
// - Errors stay latched until error reset command
module asce_top #(
	parameter int NUM_AXES = 16,
	parameter logic [31:0] MAX_SPEED = 32'h0098_9680,
	parameter logic [31:0] MIN_TIME = 32'h0000_0000,
	parameter logic [31:0] MAX_TIME = 32'h0000_fde8,
	parameter logic [31:0] MAX_POS = 32'h7fff_ffff
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asce_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [NUM_AXES-1:0] irq_in_pin,
	input wire logic [NUM_AXES-1:0][31:0] fb_pos,
	input wire logic [NUM_AXES-1:0] move_done,
	output logic [NUM_AXES-1:0] stop_req,
	output logic [NUM_AXES-1:0][31:0] feed_target,
	output logic [NUM_AXES-1:0] preset_valid,
	output logic [31:0] preset_pos,
	output logic unit_error_indicator,
	output logic [7:0] segment_display_code,
	output logic [4:0] segment_display_axis
);
	import asce_pkg::*;
	localparam int AW = $clog2(NUM_AXES);

	// Parameter registers written by the host
	logic [31:0] speed;
	logic [31:0] accel;
	logic [31:0] decel;
	logic [31:0] pos;
	logic [NUM_AXES-1:0] ifunc;
	logic [AW-1:0] axsel;
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] next_int_stat;
	logic [INT_W-1:0] int_events;
	logic [INT_W-1:0] int_clr;
	logic addr_hit;
	logic [31:0] next_rdata;
	logic next_hit;

	// Command broadcast, one axis selected per cycle
	asce_cmd_t cmd_q;
	asce_cmd_t next_cmd;
	logic [NUM_AXES-1:0] cmd_sel;
	logic [NUM_AXES-1:0] next_cmd_sel;
	logic [AW-1:0] cmd_axis;
	logic cmd_wr;
	logic preset_ok;

	// Per-axis state
	asce_axst_t axst [NUM_AXES];
	logic [NUM_AXES-1:0] err_any;
	logic [NUM_AXES-1:0] ovf_vec;
	logic [NUM_AXES-1:0] err_pulse;
	logic [NUM_AXES-1:0] ovf_pulse;
	logic [NUM_AXES-1:0] feed_done;
	logic [NUM_AXES-1:0] irq_s1;
	logic [NUM_AXES-1:0] irq_s2;
	logic [NUM_AXES-1:0] irq_prev;
	logic [NUM_AXES-1:0] irq_rise;

	// Bus phase decode
	logic setup;
	logic wr;
	logic sel_cmd;
	logic sel_speed;
	logic sel_accel;
	logic sel_decel;
	logic sel_pos;
	logic sel_ifunc;
	logic sel_axsel;
	logic sel_axstat;
	logic sel_errsum;
	logic sel_int_stat;
	logic sel_int_mask;
	logic sel_disp;
	logic sel_stopsum;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign sel_cmd = (paddr == REG_CMD);
	assign sel_speed = (paddr == REG_SPEED);
	assign sel_accel = (paddr == REG_ACCEL);
	assign sel_decel = (paddr == REG_DECEL);
	assign sel_pos = (paddr == REG_POS);
	assign sel_ifunc = (paddr == REG_IFUNC);
	assign sel_axsel = (paddr == REG_AXSEL);
	assign sel_axstat = (paddr == REG_AXSTAT);
	assign sel_errsum = (paddr == REG_ERRSUM);
	assign sel_int_stat = (paddr == REG_INT_STAT);
	assign sel_int_mask = (paddr == REG_INT_MASK);
	assign sel_disp = (paddr == REG_DISP);
	assign sel_stopsum = (paddr == REG_STOPSUM);
	assign next_hit = sel_cmd | sel_speed | sel_accel | sel_decel | sel_pos
		| sel_ifunc | sel_axsel | sel_axstat | sel_errsum | sel_int_stat
		| sel_int_mask | sel_disp | sel_stopsum;

	// Read mux; the command register reads back as zero
	assign next_rdata = ({32{sel_speed}} & speed)
		| ({32{sel_accel}} & accel)
		| ({32{sel_decel}} & decel)
		| ({32{sel_pos}} & pos)
		| ({32{sel_ifunc}} & 32'(ifunc))
		| ({32{sel_axsel}} & 32'(axsel))
		| ({32{sel_axstat}} & {19'h0, axst[axsel].ovf_state, 2'b00,
			axst[axsel].mode, 1'b0, axst[axsel].err})
		| ({32{sel_errsum}} & {32'(ovf_vec) << NUM_AXES | 32'(err_any)})
		| ({32{sel_int_stat}} & 32'(int_stat))
		| ({32{sel_int_mask}} & 32'(int_mask))
		| ({32{sel_disp}} & {19'h0, segment_display_axis, segment_display_code})
		| ({32{sel_stopsum}} & 32'(stop_req));

	// Read data is taken in the setup cycle so the access needs no wait
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prdata <= RST_WORD;
			addr_hit <= 1'b0;
		end
		else if (setup)
		begin
			prdata <= next_rdata;
			addr_hit <= next_hit;
		end
	end

	// No wait states: read data is ready from the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;

	// Parameter and configuration registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			speed <= RST_WORD;
			accel <= RST_WORD;
			decel <= RST_WORD;
			pos <= RST_WORD;
			ifunc <= '0;
			axsel <= '0;
			int_mask <= '0;
		end
		else if (wr)
		begin
			if (sel_speed)
				speed <= pwdata;
			if (sel_accel)
				accel <= pwdata;
			if (sel_decel)
				decel <= pwdata;
			if (sel_pos)
				pos <= pwdata;
			if (sel_ifunc)
				ifunc <= pwdata[NUM_AXES-1:0];
			if (sel_axsel)
				axsel <= pwdata[AW-1:0];
			if (sel_int_mask)
				int_mask <= pwdata[INT_W-1:0];
		end
	end

	// Range checks on the values that the command carries
	logic [31:0] speed_mag;
	logic [31:0] pos_mag;
	assign speed_mag = speed[31] ? (32'h0 - speed) : speed;
	assign pos_mag = pos[31] ? (32'h0 - pos) : pos;
	assign cmd_axis = pwdata[AW-1:0];
	assign next_cmd = '{
		op: asce_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]),
		speed_bad: speed_mag > MAX_SPEED,
		speed_zero: speed == 32'h0,
		speed_neg: speed[31],
		acc_bad: (accel < MIN_TIME) || (accel > MAX_TIME),
		dec_bad: (decel < MIN_TIME) || (decel > MAX_TIME),
		pos_bad: pos_mag > MAX_POS,
		ifunc_latch: ifunc[cmd_axis],
		pos: pos
	};
	// One decoded strobe feeds both the broadcast and the capture
	assign cmd_wr = wr & sel_cmd;
	assign next_cmd_sel = cmd_wr ? (NUM_AXES'(1) << cmd_axis) : '0;

	// Command stands one cycle after the write access
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cmd_q <= '0;
			cmd_sel <= '0;
		end
		else
		begin
			cmd_sel <= next_cmd_sel;
			if (cmd_wr)
				cmd_q <= next_cmd;
		end
	end

	// Good preset goes to the trajectory generator with the same strobe
	assign preset_ok = (cmd_q.op == OP_PRESET) && !cmd_q.pos_bad;
	assign preset_valid = cmd_sel & {NUM_AXES{preset_ok}};
	assign preset_pos = cmd_q.pos;

	// Interrupt pins pass two flops before the edge detector reads them
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_s1 <= '0;
			irq_s2 <= '0;
			irq_prev <= '0;
		end
		else
		begin
			irq_s1 <= irq_in_pin;
			irq_s2 <= irq_s1;
			irq_prev <= irq_s2;
		end
	end

	// Rising edge only, so a pin held high does not retrigger
	assign irq_rise = irq_s2 & ~irq_prev;

	// One checker per axis
	for (genvar g = 0; g < NUM_AXES; g++)
	begin : g_axis
		asce_axis u_axis (
			.clk(clk),
			.sys_rst(sys_rst),
			.cmd(cmd_q),
			.cmd_valid(cmd_sel[g]),
			.irq_rise(irq_rise[g]),
			.fb_pos(fb_pos[g]),
			.move_done(move_done[g]),
			.st(axst[g]),
			.stop_req(stop_req[g]),
			.err_pulse(err_pulse[g]),
			.ovf_pulse(ovf_pulse[g])
		);
		assign feed_target[g] = axst[g].target;
		assign err_any[g] = |axst[g].err;
		assign ovf_vec[g] = axst[g].ovf_state;
		assign feed_done[g] = move_done[g] & (axst[g].mode == MODE_FEED);
	end

	// Sticky events; a set in the clearing cycle wins
	assign int_events = {|feed_done, |ovf_pulse, |err_pulse};
	// Write one to clear; zeros leave the other events untouched
	assign int_clr = (wr && sel_int_stat) ? pwdata[INT_W-1:0] : '0;
	assign next_int_stat = (int_stat & ~int_clr) | int_events;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			int_stat <= '0;
		else
			int_stat <= next_int_stat;
	end

	// Level output; it falls only once software clears or masks the cause
	assign irq = |(int_stat & int_mask);

	// Front panel indication of the lowest failing axis
	asce_err_display #(
		.NUM_AXES(NUM_AXES),
		.AXW(5)
	) u_disp (
		.clk(clk),
		.sys_rst(sys_rst),
		.err_any(err_any),
		.unit_error_indicator(unit_error_indicator),
		.segment_display_code(segment_display_code),
		.segment_display_axis(segment_display_axis)
	);
endmodule

// >>> test/asce_host_model.sv
// Host bus master model for the register port
`timescale 1ns/1ps
module asce_host_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [asce_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import asce_pkg::*;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
	end
	// Request held until pready is seen high or 16 cycles pass; write data inverted when idle
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			testbench.error_cnt++;
			$display("[FAIL] pready expected 1 seen %b", pready);
			testbench.results();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0, q, e);
	endtask
endmodule

// >>> test/asce_top_props.sv
// Port-level property checker for the axis error checker
`timescale 1ns/1ps
module asce_top_props #(
	parameter int NUM_AXES = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asce_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic [NUM_AXES-1:0] stop_req,
	input wire logic [NUM_AXES-1:0] preset_valid,
	input wire logic unit_error_indicator,
	input wire logic [7:0] segment_display_code,
	input wire logic [4:0] segment_display_axis
);
	import asce_pkg::*;
	// Any command write; a stop can only end through one
	wire logic cmd_wr;
	assign cmd_wr = psel && penable && pwrite && paddr == REG_CMD;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_slverr_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_unmapped_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_rdata_setup: assert property ($changed(prdata) |-> $past(psel && !penable))
		else $error("read data moved without setup");
	a_err_shown: assert property ($rose(|stop_req) |=> unit_error_indicator)
		else $error("indicator late after stop");
	a_display_err: assert property (unit_error_indicator |->
		segment_display_code == DISP_AXIS_ERR && segment_display_axis != 5'h0)
		else $error("display wrong during error");
	a_display_idle: assert property (!unit_error_indicator |->
		segment_display_code == 8'h0 && segment_display_axis == 5'h0)
		else $error("display not blank");
	a_preset_pulse: assert property (|preset_valid |=> preset_valid == '0)
		else $error("preset pulse too long");
	a_stop_cause: assert property ($fell(|stop_req) |->
		$past(cmd_wr, 2) || $past(cmd_wr, 3) || $past(cmd_wr, 4))
		else $error("stop released without command");
	c_stop: cover property ($rose(|stop_req));
	c_slverr: cover property (pslverr);
	c_preset: cover property (|preset_valid);
	c_irq: cover property ($rose(irq));
endmodule

// >>> test/testbench.sv
// Self-checking bench for the axis error checker
`timescale 1ns/1ps
module testbench;
	import asce_pkg::*;
	localparam int NA = 4;
	localparam logic [31:0] SPD_MAX = 32'h0098_9680;
	localparam logic [31:0] TM_MAX = 32'h0000_fde8;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, uind, serr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, preset_pos, rd;
	logic [NA-1:0] irq_in_pin, move_done, stop_req, preset_valid;
	logic [NA-1:0][31:0] fb_pos, feed_target;
	logic [7:0] dcode;
	logic [4:0] daxis;
	int error_cnt, samples_checked;
	asce_top #(.NUM_AXES(NA), .MAX_SPEED(SPD_MAX), .MAX_TIME(TM_MAX)) i_dut (.clk(clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.irq_in_pin(irq_in_pin), .fb_pos(fb_pos), .move_done(move_done), .stop_req(stop_req),
		.feed_target(feed_target), .preset_valid(preset_valid), .preset_pos(preset_pos),
		.unit_error_indicator(uind), .segment_display_code(dcode),
		.segment_display_axis(daxis));
	asce_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string n);
		i_host.rd(a, rd, serr);
		chk(n, e, rd);
	endtask
	// Status is readable only two edges after the command lands
	task automatic cmd(input logic [2:0] op);
		i_host.wr(REG_CMD, {21'h0, op, 8'h0});
		repeat (4) @(posedge clk);
	endtask
	task automatic setp(input logic [31:0] s, a, d, p);
		i_host.wr(REG_SPEED, s);
		i_host.wr(REG_ACCEL, a);
		i_host.wr(REG_DECEL, d);
		i_host.wr(REG_POS, p);
	endtask
	// Pulse long enough to pass the two-flop synchroniser
	task automatic pin();
		irq_in_pin[0] <= 1'b1;
		repeat (3) @(posedge clk);
		irq_in_pin[0] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	// Settings corrected before the reset command
	task automatic erst();
		setp(32'd100, 32'd100, 32'd100, 32'd100);
		i_host.wr(REG_IFUNC, 32'h0);
		cmd(OP_ERST);
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk);
		chk("irq", 32'(e), 32'(irq));
	endtask
	task automatic bad(input logic [31:0] s, a, d, p, input logic f, input logic [2:0] op,
		input int b, input logic stp);
		setp(s, a, d, p);
		i_host.wr(REG_IFUNC, {31'h0, f});
		cmd(op);
		rchk(REG_AXSTAT, 32'h1 << b, "axis status");
		chk("stop_req", 32'(stp), 32'(stop_req[0]));
		chk("indicator", 32'h1, 32'(uind));
		chk("display", {19'h0, 5'h01, DISP_AXIS_ERR}, {19'h0, daxis, dcode});
		i_host.wr(REG_INT_MASK, 32'h0);
		irq_is(1'b0);
		i_host.wr(REG_INT_MASK, 32'h1);
		irq_is(1'b1);
		i_host.wr(REG_INT_STAT, 32'h7);
		irq_is(1'b0);
		rchk(REG_AXSTAT, 32'h1 << b, "latched status");
		erst();
		rchk(REG_AXSTAT, 32'h0, "cleared status");
		$display("error case %0d done", b);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		sys_rst = 1'b1;
		irq_in_pin = '0;
		move_done = '0;
		fb_pos = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		fb_pos[0] <= 32'h0000_1000;
		rchk(REG_INT_STAT, 32'h0, "int status");
		rchk(REG_ERRSUM, 32'h0, "error summary");
		i_host.rd(8'hfc, rd, serr);
		chk("slverr", 32'h1, 32'(serr));
		i_host.wr(REG_AXSEL, 32'h0);
		$display("reset test done");
		bad(SPD_MAX + 1, 100, 100, 100, 1'b0, OP_SPEED, ERR_SPEED, 1'b1);
		bad(100, TM_MAX + 1, 100, 100, 1'b0, OP_SPEED, ERR_ACC, 1'b1);
		bad(100, 100, TM_MAX + 1, 100, 1'b0, OP_SPEED, ERR_DEC, 1'b1);
		bad(100, 100, 100, 32'h8000_0000, 1'b0, OP_IFEED, ERR_POS, 1'b1);
		bad(100, 100, 100, 100, 1'b1, OP_IFEED, ERR_IFUNC, 1'b0);
		// Feeding faults found while waiting and while moving
		setp(32'd0, 32'd100, 32'd100, 32'd100);
		cmd(OP_IFEED);
		pin();
		rchk(REG_AXSTAT, 32'h1, "zero at interrupt");
		erst();
		cmd(OP_IFEED);
		rchk(REG_AXSTAT, 32'h200, "waiting");
		i_host.wr(REG_SPEED, -32'sd100);
		cmd(OP_CHSPD);
		rchk(REG_AXSTAT, 32'h1, "sign reversal");
		erst();
		cmd(OP_IFEED);
		pin();
		rchk(REG_AXSTAT, 32'h300, "feeding");
		chk("target", 32'h0000_1064, feed_target[0]);
		i_host.wr(REG_SPEED, 32'h0);
		cmd(OP_CHSPD);
		rchk(REG_AXSTAT, 32'h1, "zero while feeding");
		erst();
		// Completed move ends feeding and raises the done event
		cmd(OP_IFEED);
		pin();
		move_done[0] <= 1'b1;
		@(posedge clk);
		move_done[0] <= 1'b0;
		repeat (2) @(posedge clk);
		rchk(REG_AXSTAT, 32'h0, "feeding done");
		rchk(REG_INT_STAT, 32'h5, "done event");
		i_host.wr(REG_INT_STAT, 32'h7);
		cmd(OP_SPEED);
		rchk(REG_AXSTAT, 32'h100, "speed control");
		cmd(OP_STOP);
		rchk(REG_AXSTAT, 32'h0, "stopped");
		$display("feeding test done");
		// Capture overflow survives error reset and a bad preset until a good preset
		fb_pos[0] <= 32'h7fff_fff0;
		cmd(OP_IFEED);
		pin();
		rchk(REG_AXSTAT, 32'h1020, "overflow");
		chk("stop_req", 32'h1, 32'(stop_req[0]));
		rchk(REG_INT_STAT, 32'h3, "overflow event");
		rchk(REG_STOPSUM, 32'h1, "stop summary");
		rchk(REG_DISP, {19'h0, 5'h01, DISP_AXIS_ERR}, "display register");
		erst();
		rchk(REG_AXSTAT, 32'h1000, "overflow kept");
		rchk(REG_ERRSUM, 32'h10, "overflow summary");
		i_host.wr(REG_POS, 32'h8000_0000);
		cmd(OP_PRESET);
		rchk(REG_AXSTAT, 32'h1040, "bad preset");
		chk("stop_req", 32'h0, 32'(stop_req[0]));
		erst();
		i_host.wr(REG_POS, 32'h0000_0123);
		i_host.wr(REG_CMD, {21'h0, OP_PRESET, 8'h0});
		@(negedge clk);
		chk("preset_valid", 32'h1, 32'(preset_valid[0]));
		repeat (4) @(posedge clk);
		chk("preset_pos", 32'h0000_0123, preset_pos);
		rchk(REG_AXSTAT, 32'h0, "overflow cleared");
		$display("overflow test done");
		results();
	end
endmodule
bind asce_top asce_top_props #(.NUM_AXES(NUM_AXES)) i_props (.clk(clk), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .stop_req(stop_req),
	.preset_valid(preset_valid), .unit_error_indicator(unit_error_indicator),
	.segment_display_code(segment_display_code), .segment_display_axis(segment_display_axis));
